// File: hw/msc_pkg.sv
// shared constants and types of the serial controller
package msc_pkg;
    localparam int          DATA_W           = 8;
    localparam int          FIFO_DEPTH       = 16;
    localparam int          SYNC_W           = 4;
    localparam int          CNT_W            = 4;
    localparam int          SLAVE_SCK_RATIO  = 8;
    // synchroniser bit positions
    localparam int          SYN_SCK          = 0;
    localparam int          SYN_SS           = 1;
    localparam int          SYN_MOSI         = 2;
    localparam int          SYN_MISO         = 3;
    localparam logic [3:0]  SYNC_RST         = 4'h2;
    localparam logic [16:0] DIV_ZERO_RELOAD  = 17'h10000;
    localparam logic [16:0] DIV_ONE          = 17'h00001;
    localparam logic [2:0]  CHAR_CODE_FULL   = 3'h0;
    localparam logic [3:0]  CHAR_LEN_FULL    = 4'h8;
    localparam logic        SELECT_STAT_RST  = 1'b1;
    localparam logic [7:0]  SHIFT_RST        = 8'h00;

    typedef enum logic [1:0] {
        MSC_IDLE,
        MSC_WAIT,
        MSC_RUN
    } msc_mst_state_t;
endpackage

// File: hw/msc_stream_if.sv
// valid/ready word stream between the controller and its receive fifo
`timescale 1ns/1ps
interface msc_stream_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface // msc_stream_if

// File: hw/msc_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module msc_sync #(
    parameter int           W       = 4,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                s1_q[i] <= RST_VAL[i];
                s2_q[i] <= RST_VAL[i];
                s3_q[i] <= RST_VAL[i];
                q_o[i]  <= RST_VAL[i];
            end else begin
                s1_q[i] <= d_i[i];
                s2_q[i] <= s1_q[i];
                s3_q[i] <= s2_q[i];
                // a change counts only once stages two and three agree
                if (s2_q[i] == s3_q[i]) begin
                    q_o[i] <= s3_q[i];
                end
            end
        end
    end
endmodule // msc_sync

// File: hw/msc_fifo.sv
// parameterised receive fifo with registered status
`timescale 1ns/1ps
module msc_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    input  wire logic clk,
    input  wire logic rst_n,
    msc_stream_if.snk in_if,
    msc_stream_if.src out_if
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]   cnt_q, cnt_d;
    logic          push, pop;

    assign in_if.ready  = (cnt_q != DEPTH[AW:0]);
    assign out_if.valid = (cnt_q != '0);
    assign out_if.data  = mem_q[rd_q];

    always_comb begin
        push  = in_if.valid && in_if.ready;
        pop   = out_if.valid && out_if.ready;
        wr_d  = push ? AW'(wr_q + 1'b1) : wr_q;
        rd_d  = pop ? AW'(rd_q + 1'b1) : rd_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = (AW+1)'(cnt_q + 1'b1);
        end else if (pop && !push) begin
            cnt_d = (AW+1)'(cnt_q - 1'b1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_if.data;
        end
    end
endmodule // msc_fifo

// File: hw/msc_ctrl.sv
// master/slave serial controller with rate divider, timer and receive fifo
`timescale 1ns/1ps
module msc_ctrl
    import msc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        unit_enable_bit,
    input  wire logic        master_select_bit,
    input  wire logic        select_pin_direction,
    input  wire logic        select_pin_value,
    input  wire logic        interrupt_enable_bit,
    input  wire logic        clock_phase_bit,
    input  wire logic        clock_polarity_bit,
    input  wire logic        open_drain_bit,
    input  wire logic [2:0]  char_length_field,
    input  wire logic        force_interrupt_bit,
    input  wire logic        timer_interrupt_enable,
    input  wire logic [7:0]  divider_high_byte,
    input  wire logic [7:0]  divider_low_byte,
    input  wire logic        data_wr,
    input  wire logic [7:0]  data_wdata,
    input  wire logic        clr_irq,
    input  wire logic        clr_overrun,
    input  wire logic        clr_collision,
    input  wire logic        clr_abort,
    output logic             rx_valid,
    input  wire logic        rx_ready,
    output logic      [7:0]  rx_data,
    output logic      [7:0]  shift_data,
    output logic             irq_flag,
    output logic             overrun_flag,
    output logic             collision_flag,
    output logic             abort_flag,
    output logic             transfer_busy,
    output logic             select_status,
    output logic             spi_irq,
    input  wire logic        sck_i,
    output logic             sck_o,
    output logic             sck_oe_n,
    input  wire logic        mosi_i,
    output logic             mosi_o,
    output logic             mosi_oe_n,
    input  wire logic        miso_i,
    output logic             miso_o,
    output logic             miso_oe_n,
    input  wire logic        ss_n_i,
    output logic             ss_n_o,
    output logic             ss_n_oe_n
);
    // ------------------------------------------------------------
    // input synchronisers and receive fifo
    // ------------------------------------------------------------
    logic [SYNC_W-1:0] syn;
    logic              sck_s, ss_n_s, mosi_s, miso_s;

    msc_sync #(.W(SYNC_W), .RST_VAL(SYNC_RST)) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d_i   ({miso_i, mosi_i, ss_n_i, sck_i}),
        .q_o   (syn)
    );
    assign sck_s  = syn[SYN_SCK];
    assign ss_n_s = syn[SYN_SS];
    assign mosi_s = syn[SYN_MOSI];
    assign miso_s = syn[SYN_MISO];

    msc_stream_if #(.W(DATA_W)) push_if ();
    msc_stream_if #(.W(DATA_W)) pop_if ();

    msc_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk    (clk),
        .rst_n  (rst_n),
        .in_if  (push_if.snk),
        .out_if (pop_if.src)
    );
    assign rx_valid     = pop_if.valid;
    assign rx_data      = pop_if.data;
    assign pop_if.ready = rx_ready;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    msc_mst_state_t st_q, st_d;
    logic [16:0]    div_q, div_d;
    logic [7:0]     shf_q, shf_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic           bit_q, bit_d, have_q, have_d, done_q, done_d;
    logic           act_q, act_d, sck_prev_q, ss_prev_q;
    logic           irq_q, irq_d, ovr_q, ovr_d, col_q, col_d, abt_q, abt_d;
    logic           push_q, push_d;
    logic [7:0]     push_dat_q, push_dat_d;
    logic           sck_o_d, sck_oe_d, mosi_o_d, mosi_oe_d, miso_o_d, miso_oe_d;
    logic           ss_o_d, ss_oe_d, busy_d, sel_d, sirq_d;

    logic [16:0]    reload;
    logic [CNT_W-1:0] nbits;
    logic           en, mst, slv, sel, tick, lead, smp_ev, shf_ev;
    logic           busy, complete, abort_ev;

    assign push_if.valid = push_q;
    assign push_if.data  = push_dat_q;

    always_comb begin
        en     = unit_enable_bit;
        mst    = en && master_select_bit;
        slv    = en && !master_select_bit;
        sel    = slv && !ss_n_s;
        reload = ({divider_high_byte, divider_low_byte} == 16'h0000)
                 ? DIV_ZERO_RELOAD : {1'b0, divider_high_byte, divider_low_byte};
        nbits  = (char_length_field == CHAR_CODE_FULL)
                 ? CHAR_LEN_FULL : {1'b0, char_length_field};
        busy   = (st_q != MSC_IDLE) || sel;

        st_d       = st_q;
        div_d      = div_q;
        shf_d      = shf_q;
        cnt_d      = cnt_q;
        bit_d      = bit_q;
        have_d     = have_q;
        done_d     = done_q;
        act_d      = act_q;
        irq_d      = irq_q;
        ovr_d      = ovr_q;
        col_d      = col_q;
        abt_d      = abt_q;
        push_d     = 1'b0;
        push_dat_d = push_dat_q;
        tick       = 1'b0;
        smp_ev     = 1'b0;
        shf_ev     = 1'b0;
        complete   = 1'b0;
        abort_ev   = 1'b0;
        lead       = 1'b0;

        // rate divider: one tick per half serial period
        if ((st_q == MSC_RUN) || (!en && timer_interrupt_enable)) begin
            if (div_q <= DIV_ONE) begin
                tick  = 1'b1;
                div_d = reload;
            end else begin
                div_d = 17'(div_q - 1'b1);
            end
        end else begin
            div_d = reload;
        end

        // edge events from divider (master) or synchronised clock (slave)
        if (st_q == MSC_RUN && tick) begin
            lead   = !act_q;
            act_d  = !act_q;
            smp_ev = (lead != clock_phase_bit);
            shf_ev = (lead == clock_phase_bit);
        end else if (sel && (sck_s != sck_prev_q)) begin
            lead   = (sck_s != clock_polarity_bit);
            smp_ev = (lead != clock_phase_bit);
            shf_ev = (lead == clock_phase_bit);
        end

        // shift engine, msb first, received bits enter at bit 0
        if (smp_ev) begin
            bit_d  = mst ? miso_s : mosi_s;
            have_d = 1'b1;
            if (cnt_q == CNT_W'(nbits - 1'b1)) begin
                shf_d    = {shf_q[6:0], bit_d};
                have_d   = 1'b0;
                cnt_d    = '0;
                complete = 1'b1;
            end else begin
                cnt_d = CNT_W'(cnt_q + 1'b1);
            end
        end else if (shf_ev && have_q) begin
            shf_d  = {shf_q[6:0], bit_q};
            have_d = 1'b0;
        end

        if (complete) begin
            irq_d      = 1'b1;
            push_dat_d = shf_d;
            push_d     = push_if.ready;
            if (!push_if.ready) begin
                ovr_d = 1'b1;
            end
        end

        // slave released mid character
        if (slv && ss_n_s && !ss_prev_q && ((cnt_q != '0) || have_q)) begin
            abort_ev = 1'b1;
            abt_d    = 1'b1;
            irq_d    = 1'b1;
            cnt_d    = '0;
            have_d   = 1'b0;
        end

        // master sequencing
        case (st_q)
            MSC_IDLE: begin
                act_d  = 1'b0;
                done_d = 1'b0;
            end
            MSC_WAIT: begin
                if (push_if.ready) begin
                    st_d = MSC_RUN;
                end
            end
            MSC_RUN: begin
                if (complete) begin
                    done_d = 1'b1;
                end
                if (tick && !lead && (done_q || complete)) begin
                    st_d = MSC_IDLE;
                end
                if (!mst) begin
                    st_d  = MSC_IDLE;
                    cnt_d = '0;
                end
            end
            default: st_d = MSC_IDLE;
        endcase

        // data register write
        if (data_wr) begin
            if (busy) begin
                ovr_d = 1'b1;
            end else begin
                shf_d = data_wdata;
                cnt_d = '0;
                have_d = 1'b0;
                if (mst) begin
                    st_d = push_if.ready ? MSC_RUN : MSC_WAIT;
                end
            end
        end

        if (mst && !select_pin_direction && !ss_n_s) begin
            col_d = 1'b1;
        end
        if (en && force_interrupt_bit) begin
            irq_d = 1'b1;
        end

        // write-one clears; a same-cycle set wins
        if (clr_irq && irq_q && !(complete || abort_ev || force_interrupt_bit)) begin
            irq_d = 1'b0;
        end
        if (clr_overrun && ovr_q && !(data_wr && busy) && !(complete && !push_if.ready)) begin
            ovr_d = 1'b0;
        end
        if (clr_collision && col_q && !(mst && !select_pin_direction && !ss_n_s)) begin
            col_d = 1'b0;
        end
        if (clr_abort && abt_q && !abort_ev) begin
            abt_d = 1'b0;
        end
        if (!en) begin
            irq_d = 1'b0;
            ovr_d = 1'b0;
            col_d = 1'b0;
            abt_d = 1'b0;
        end

        // pins: open-drain pulls low only; enable is active low
        sck_o_d   = clock_polarity_bit ^ act_d;
        sck_oe_d  = !(mst && (!open_drain_bit || !sck_o_d));
        mosi_o_d  = smp_ev ? mosi_o : shf_d[7];
        mosi_oe_d = !(mst && (!open_drain_bit || !mosi_o_d));
        miso_o_d  = shf_d[7];
        miso_oe_d = !(sel && (!open_drain_bit || !miso_o_d));
        ss_o_d    = select_pin_value;
        ss_oe_d   = !(mst && select_pin_direction && (!open_drain_bit || !ss_o_d));
        busy_d    = (st_d != MSC_IDLE) || sel;
        sel_d     = en ? ss_n_s : SELECT_STAT_RST;
        sirq_d    = (interrupt_enable_bit && irq_d)
                    || (!en && timer_interrupt_enable && tick);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q           <= MSC_IDLE;
            div_q          <= DIV_ZERO_RELOAD;
            shf_q          <= SHIFT_RST;
            cnt_q          <= '0;
            bit_q          <= 1'b0;
            have_q         <= 1'b0;
            done_q         <= 1'b0;
            act_q          <= 1'b0;
            sck_prev_q     <= SYNC_RST[SYN_SCK];
            ss_prev_q      <= SYNC_RST[SYN_SS];
            irq_q          <= 1'b0;
            ovr_q          <= 1'b0;
            col_q          <= 1'b0;
            abt_q          <= 1'b0;
            push_q         <= 1'b0;
            push_dat_q     <= SHIFT_RST;
            sck_o          <= 1'b0;
            sck_oe_n       <= 1'b1;
            mosi_o         <= 1'b0;
            mosi_oe_n      <= 1'b1;
            miso_o         <= 1'b0;
            miso_oe_n      <= 1'b1;
            ss_n_o         <= 1'b1;
            ss_n_oe_n      <= 1'b1;
            transfer_busy  <= 1'b0;
            select_status  <= SELECT_STAT_RST;
            spi_irq        <= 1'b0;
        end else begin
            st_q           <= st_d;
            div_q          <= div_d;
            shf_q          <= shf_d;
            cnt_q          <= cnt_d;
            bit_q          <= bit_d;
            have_q         <= have_d;
            done_q         <= done_d;
            act_q          <= act_d;
            sck_prev_q     <= sck_s;
            ss_prev_q      <= ss_n_s;
            irq_q          <= irq_d;
            ovr_q          <= ovr_d;
            col_q          <= col_d;
            abt_q          <= abt_d;
            push_q         <= push_d;
            push_dat_q     <= push_dat_d;
            sck_o          <= sck_o_d;
            sck_oe_n       <= sck_oe_d;
            mosi_o         <= mosi_o_d;
            mosi_oe_n      <= mosi_oe_d;
            miso_o         <= miso_o_d;
            miso_oe_n      <= miso_oe_d;
            ss_n_o         <= ss_o_d;
            ss_n_oe_n      <= ss_oe_d;
            transfer_busy  <= busy_d;
            select_status  <= sel_d;
            spi_irq        <= sirq_d;
        end
    end

    assign shift_data     = shf_q;
    assign irq_flag       = irq_q;
    assign overrun_flag   = ovr_q;
    assign collision_flag = col_q;
    assign abort_flag     = abt_q;
endmodule // msc_ctrl

// File: bench/msc_monitor.sv
// concurrent checks on the serial controller ports
`timescale 1ns/1ps
module msc_monitor
    import msc_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       unit_enable_bit,
    input wire logic       master_select_bit,
    input wire logic       select_pin_direction,
    input wire logic       interrupt_enable_bit,
    input wire logic       force_interrupt_bit,
    input wire logic [7:0] divider_high_byte,
    input wire logic [7:0] divider_low_byte,
    input wire logic       data_wr,
    input wire logic       clr_irq,
    input wire logic       clr_overrun,
    input wire logic       irq_flag,
    input wire logic       overrun_flag,
    input wire logic       collision_flag,
    input wire logic       abort_flag,
    input wire logic       transfer_busy,
    input wire logic       spi_irq,
    input wire logic       sck_o,
    input wire logic       ss_n_i
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ----
    // serial clock level length, counted while a character runs
    // ----
    logic [16:0] run_q, run_d, reload;
    logic        sck_q, sck_d, tog_q, tog_d;
    always_comb begin
        reload = ({divider_high_byte, divider_low_byte} == 16'h0000) ? DIV_ZERO_RELOAD
                                                                     : {1'b0, divider_high_byte, divider_low_byte};
        sck_d = sck_o;
        run_d = (sck_o != sck_q) ? 17'h00001 : run_q + 17'h00001;
        tog_d = transfer_busy && (tog_q || sck_o != sck_q);
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_q <= 17'h00000;
            sck_q <= 1'b0;
            tog_q <= 1'b0;
        end else begin
            run_q <= run_d;
            sck_q <= sck_d;
            tog_q <= tog_d;
        end
    end
    sck_half_a: assert property (unit_enable_bit && master_select_bit && tog_q && sck_o != sck_q |-> run_q == reload)
        else $error("serial clock level length differs from reload");
    ovr_set_a: assert property (unit_enable_bit && data_wr && transfer_busy |=> overrun_flag)
        else $error("write during transfer did not set overrun");
    ovr_clr_a: assert property (unit_enable_bit && master_select_bit && clr_overrun && !data_wr |=> !overrun_flag)
        else $error("overrun did not clear");
    coll_set_a: assert property ((unit_enable_bit && master_select_bit && !select_pin_direction && !ss_n_i) [*8] |=> collision_flag)
        else $error("select low in master mode did not set collision");
    force_irq_a: assert property (unit_enable_bit && force_interrupt_bit |=> irq_flag)
        else $error("force pulse did not set interrupt flag");
    irq_clr_a: assert property ((!transfer_busy) [*3] ##0 (unit_enable_bit && master_select_bit && clr_irq && !force_interrupt_bit) |=> !irq_flag)
        else $error("interrupt flag did not clear");
    irq_gate_a: assert property ((unit_enable_bit && !interrupt_enable_bit) [*2] |-> !spi_irq)
        else $error("interrupt request while disabled");
    irq_level_a: assert property ((unit_enable_bit && interrupt_enable_bit && irq_flag) [*2] |-> spi_irq)
        else $error("pending flag not requested");
    timer_flag_a: assert property (!unit_enable_bit |=> !irq_flag && !overrun_flag && !collision_flag)
        else $error("flag set while unit disabled");
    cover property ($rose(irq_flag) && master_select_bit);
    cover property ($rose(abort_flag));
    cover property ($rose(collision_flag));
endmodule // msc_monitor
bind msc_ctrl msc_monitor u_msc_monitor (.*);

// File: bench/msc_partner.sv
// external serial slave answering the controller in master mode
`timescale 1ns/1ps
module msc_partner (
    input  wire logic       sck,
    input  wire logic       ss_n,
    input  wire logic       mosi,
    input  wire logic [7:0] tx,
    output logic            miso,
    output logic      [7:0] rx
);
    logic [7:0] sh_q;
    initial begin
        miso = 1'b1;
        rx = 8'h00;
        sh_q = 8'h00;
    end
    always @(negedge ss_n) begin
        sh_q = tx;
        miso = tx[7];
    end
    always @(posedge sck) begin
        if (!ss_n) rx = {rx[6:0], mosi};
    end
    always @(negedge sck) begin
        if (!ss_n) sh_q = {sh_q[6:0], 1'b0};
        if (!ss_n) miso = sh_q[7];
    end
    // released line never keeps a stale bit
    always @(posedge ss_n) begin
        miso = ~miso;
    end
endmodule // msc_partner

// File: bench/msc_ctrl_bench.sv
// self-checking bench for the serial controller
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fails++; $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module msc_ctrl_bench;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       unit_enable_bit, master_select_bit, select_pin_direction, select_pin_value;
    logic       interrupt_enable_bit, clock_phase_bit, clock_polarity_bit, open_drain_bit;
    logic [2:0] char_length_field;
    logic       force_interrupt_bit, timer_interrupt_enable, data_wr, rx_ready;
    logic       clr_irq, clr_overrun, clr_collision, clr_abort;
    logic [7:0] divider_high_byte, divider_low_byte, data_wdata, rx_data, shift_data, p_tx, p_rx, got;
    logic       rx_valid, irq_flag, overrun_flag, collision_flag, abort_flag, transfer_busy, select_status;
    logic       spi_irq, sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n, ss_n_o, ss_n_oe_n;
    logic       b_sck, b_ss_n, b_mosi, p_miso;
    wire logic  sck_i = sck_oe_n ? b_sck : sck_o;
    wire logic  ss_n_i = ss_n_oe_n ? b_ss_n : ss_n_o;
    wire logic  mosi_i = mosi_oe_n ? b_mosi : mosi_o;
    wire logic  miso_i = miso_oe_n ? p_miso : miso_o;
    int         fails = 0;
    int         cmp_count = 0;
    int         n;
    always #10 clk = ~clk;
    msc_ctrl u_msc_ctrl (.*);
    msc_partner u_msc_partner (.sck(sck_i), .ss_n(ss_n_i), .mosi(mosi_i), .tx(p_tx), .miso(p_miso), .rx(p_rx));
    // ----
    // access tasks
    // ----
    task automatic tick(input int c);
        repeat (c) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] d);
        data_wr <= 1'b1;
        data_wdata <= d;
        tick(1);
        data_wr <= 1'b0;
    endtask
    task automatic pulse(input logic [4:0] m);
        {force_interrupt_bit, clr_irq, clr_overrun, clr_collision, clr_abort} <= m;
        tick(1);
        {force_interrupt_bit, clr_irq, clr_overrun, clr_collision, clr_abort} <= 5'h00;
    endtask
    task automatic wait_until(input bit w);
        int k;
        k = 0;
        while (((w ? irq_flag : ~transfer_busy) !== 1'b1) && k < 5000) begin
            tick(1);
            k++;
        end
        if (k == 5000) `CHK(k, 0)
    endtask
    // external master driving the unit in slave mode, 16 clocks per bit
    task automatic sxfer(input logic [7:0] d, input int c);
        got = 8'h00;
        b_ss_n <= 1'b0;
        tick(8);
        for (int i = 0; i < c; i++) begin
            b_mosi <= d[7-i];
            tick(8);
            b_sck <= 1'b1;
            got = {got[6:0], miso_i};
            tick(8);
            b_sck <= 1'b0;
        end
        tick(8);
    endtask
    task automatic test_done();
        $display("fails=%0d cmp_count=%0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #200us;
        fails++;
        $display("unexpected at %0t: watchdog expired", $time);
        test_done();
    end
    // ----
    // test sequence
    // ----
    initial begin
        {unit_enable_bit, master_select_bit, select_pin_direction, select_pin_value, interrupt_enable_bit} = '0;
        {clock_phase_bit, clock_polarity_bit, open_drain_bit, char_length_field, force_interrupt_bit} = '0;
        {timer_interrupt_enable, data_wr, rx_ready, clr_irq, clr_overrun, clr_collision, clr_abort} = '0;
        {divider_high_byte, divider_low_byte, data_wdata, p_tx, got, b_sck, b_mosi} = '0;
        b_ss_n = 1'b1;
        tick(5);
        rst_n <= 1'b1;
        tick(2);
        `CHK({select_status, shift_data, irq_flag, overrun_flag, collision_flag, abort_flag}, 13'h1000)
        {unit_enable_bit, master_select_bit, select_pin_direction, select_pin_value} <= 4'hf;
        {interrupt_enable_bit, divider_low_byte, p_tx} <= {1'b1, 8'h08, 8'h3c};
        tick(4);
        select_pin_value <= 1'b0;
        tick(4);
        wr(8'ha5);
        tick(3);
        wr(8'h11);
        tick(2);
        `CHK(overrun_flag, 1'b1)
        wait_until(1'b1);
        tick(12);
        `CHK({shift_data, p_rx, rx_data, spi_irq}, {8'h3c, 8'ha5, 8'h3c, 1'b1})
        pulse(5'h0c);
        tick(2);
        `CHK({irq_flag, overrun_flag}, 2'b00)
        {char_length_field, select_pin_value, p_tx, open_drain_bit} <= {3'h4, 1'b1, 8'hc0, 1'b1};
        tick(3);
        `CHK({sck_oe_n, ss_n_oe_n}, 2'b01)
        {open_drain_bit, select_pin_value} <= 2'b00;
        tick(4);
        wr(8'ha0);
        wait_until(1'b1);
        tick(12);
        `CHK({shift_data, p_rx[3:0]}, {8'h0c, 4'ha})
        {char_length_field, divider_low_byte} <= {3'h0, 8'h01};
        tick(2);
        repeat (14) begin
            wr(8'h55);
            tick(2);
            wait_until(1'b0);
        end
        wr(8'h66);
        tick(40);
        `CHK(transfer_busy, 1'b1) // fifo full stalls the start
        rx_ready <= 1'b1;
        n = 0;
        repeat (100) begin
            tick(1);
            n += int'(rx_valid === 1'b1);
        end
        rx_ready <= 1'b0;
        `CHK(n, 17) // whole fifo drained plus the stalled word
        select_pin_direction <= 1'b0;
        b_ss_n <= 1'b0;
        tick(10);
        `CHK(collision_flag, 1'b1)
        b_ss_n <= 1'b1;
        tick(8);
        pulse(5'h02);
        tick(2);
        `CHK(collision_flag, 1'b0)
        pulse(5'h08);
        tick(2);
        `CHK(irq_flag, 1'b0)
        pulse(5'h10);
        tick(2);
        `CHK({irq_flag, spi_irq}, 2'b11)
        interrupt_enable_bit <= 1'b0;
        tick(3);
        `CHK(spi_irq, 1'b0)
        {interrupt_enable_bit, master_select_bit} <= 2'b10;
        pulse(5'h08);
        tick(2);
        wr(8'h96);
        tick(2);
        sxfer(8'h5a, 8);
        `CHK({got, shift_data, irq_flag}, {8'h96, 8'h5a, 1'b1})
        pulse(5'h08);
        tick(2);
        sxfer(8'h13, 8);
        `CHK({got, irq_flag}, {8'h5a, 1'b1})
        pulse(5'h08);
        tick(2);
        sxfer(8'hf0, 2);
        b_ss_n <= 1'b1;
        tick(10);
        `CHK({abort_flag, irq_flag, shift_data}, {2'b11, 8'h4f})
        b_ss_n <= 1'b0;
        tick(8);
        `CHK({miso_oe_n, miso_o}, 2'b00)
        b_ss_n <= 1'b1;
        tick(8);
        pulse(5'h01);
        tick(2);
        `CHK(abort_flag, 1'b0)
        unit_enable_bit <= 1'b0;
        tick(1);
        divider_low_byte <= 8'h05;
        tick(1);
        timer_interrupt_enable <= 1'b1;
        tick(10);
        n = 0;
        repeat (100) begin
            tick(1);
            n += int'(spi_irq === 1'b1);
        end
        `CHK({n == 20, irq_flag}, 2'b10)
        test_done();
    end
endmodule // msc_ctrl_bench
